// [verilog/mcr_pkg.sv]
package mcr_pkg;

  // ==========================================================
  // Register map
  localparam logic [5:0] MODE_ADDR = 6'h09;
  localparam logic [5:0] HALFCYC_ADDR = 6'h1C;
  localparam logic [15:0] MODE_RESET = 16'h000C;
  localparam logic [15:0] HALFCYC_RESET = 16'hFFFF;

  // ==========================================================
  // Command byte layout
  localparam int CMD_DIR_BIT = 7;
  localparam int CMD_ADDR_MSB = 5;
  localparam logic [4:0] CMD_BITS = 5'h08;

  // ==========================================================
  // Operating configuration bit positions
  localparam int MODE_HPF_BIT = 0;
  localparam int MODE_LOWPASS_BIT = 1;
  localparam int MODE_PULSE_BIT = 2;
  localparam int MODE_DIP_BIT = 3;
  localparam int MODE_PWRDN_BIT = 4;
  localparam int MODE_TEMP_BIT = 5;
  localparam int MODE_SOFTRST_BIT = 6;
  localparam int MODE_CYC_BIT = 7;

  // ==========================================================
  // Timing: quiet time after a software reset
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFTRST_QUIET_NS = 18000;
  localparam int SOFTRST_QUIET_CYC = (SOFTRST_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SOFTRST_QUIET_CNT = 8'(SOFTRST_QUIET_CYC);

  // ==========================================================
  // Serial front end states
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_WDATA = 2'b01,
    ST_RDATA = 2'b10
  } mcr_state_type;

endpackage

// [verilog/mcr_bit_sync.sv]
`timescale 1ns/10ps
module mcr_bit_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // The first stage feeds only the second stage
  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  // Two-stage capture, frozen with the clock enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else if (ce) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule

// [verilog/mcr_cmd_mode_regs.sv]
// Contract
// RQ1: Command register is eight bits, write only, never read back.
// RQ2: Host opens each transfer with a command byte, then moves data.
// RQ3: Command bits 0 to 5 give the target register index.
// RQ4: Host writes zero into command bit 6.
// RQ5: Command bit 7 one means write, zero means read.
// RQ6: Configuration comes from the operating register at index 0x09.
// RQ7: Mode bit 0 bypasses channel 1 highpass; resets to zero.
// RQ8: Mode bit 1 bypasses second lowpass; resets to zero.
// RQ9: Mode bit 2 disables pulse output; resets to one.
// RQ10: Mode bit 3 disables dip detection; resets to one.
// RQ11: Mode bit 4 powers down both converters; resets to zero.
// RQ12: Mode bit 5 starts thermal conversion; hardware clears it when done.
// RQ13: Mode bit 6 resets the chip by software; reads zero.
// RQ14: Host waits at least 18 us after software reset.
// RQ15: Mode bit 7 selects half-cycle accumulation; resets to zero.
// RQ16: Half-cycle count register is 16 bits, resets to all ones.
// RQ17: Data bytes equal register width in bytes, most significant first.
`timescale 1ns/10ps
module mcr_cmd_mode_regs
  import mcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic din,
  input wire logic csN,
  input wire logic thermalConvDone,
  output logic dout,
  output logic doutOe,
  output logic ch1HighpassBypass,
  output logic powerLowpassBypass,
  output logic pulseOutDisable,
  output logic dipDetectDisable,
  output logic converterPowerdown,
  output logic thermalConvStart,
  output logic halfcycleAccumMode,
  output logic softChipReset,
  output logic [15:0] halfcycleCount,
  output logic [7:0] modeUpper
);
  import mcr_pkg::*;

  // ==========================================================
  // Register width and read data
  function automatic logic [1:0] regBytes(input logic [5:0] idx);
    regBytes = (idx == MODE_ADDR || idx == HALFCYC_ADDR) ? 2'h2 : 2'h1; // RQ17
  endfunction

  // The command byte has no read path; unmapped indices read zero
  function automatic logic [15:0] readAligned(input logic [5:0] idx, input logic [15:0] modeV,
                                              input logic [15:0] cycV);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == MODE_ADDR) begin
      v = modeV;
    end else if (idx == HALFCYC_ADDR) begin
      v = cycV;
    end
    // Narrow registers are left aligned so the top bit leaves first
    readAligned = (regBytes(idx) == 2'd2) ? v : {v[7:0], 8'h00}; // RQ17 RQ1
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic sclkS;
  logic dinS;
  logic csNS;

  mcr_bit_sync #(.W(3), .RST_VAL(3'b100)) uSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .asyncIn({csN, sclk, din}),
    .syncOut({csNS, sclkS, dinS})
  );

  // ==========================================================
  // State
  mcr_state_type stR, stNxt;
  logic [4:0] bitsLeftR, bitsLeftNxt;
  logic [15:0] shiftR, shiftNxt;
  logic [5:0] addrR, addrNxt;
  logic [15:0] modeR, modeNxt;
  logic [15:0] lineCycR, lineCycNxt;
  logic [7:0] holdCntR, holdCntNxt;
  logic sclkD_r, sclkD_nxt;
  logic softRstR, softRstNxt;
  logic doutR, doutNxt;
  logic doutOeR, doutOeNxt;

  logic sclkFall;
  logic sclkRise;
  logic active;
  logic [7:0] cmdByte;
  logic [15:0] wrData;
  logic cmdDone;
  logic wrCommit;

  // Edge detection works on the second synchroniser stage only
  assign sclkFall = sclkD_r & ~sclkS;
  assign sclkRise = ~sclkD_r & sclkS;
  // The serial port is deaf while deselected or in the reset quiet time
  assign active = ce && !csNS && (holdCntR == 8'h00);
  assign cmdByte = {shiftR[6:0], dinS};
  assign wrData = {shiftR[14:0], dinS};
  assign cmdDone = active && (stR == ST_CMD) && sclkFall && (bitsLeftR == 5'h01);
  assign wrCommit = active && (stR == ST_WDATA) && sclkFall && (bitsLeftR == 5'h01);

  // ==========================================================
  // Next-state logic for the serial front end and registers
  always_comb begin
    stNxt = stR;
    bitsLeftNxt = bitsLeftR;
    shiftNxt = shiftR;
    addrNxt = addrR;
    modeNxt = modeR;
    lineCycNxt = lineCycR;
    holdCntNxt = holdCntR;
    sclkD_nxt = sclkS;
    softRstNxt = 1'b0;
    doutNxt = doutR;
    doutOeNxt = doutOeR;
    if (holdCntR != 8'h00) begin
      holdCntNxt = holdCntR - 8'h01;
    end
    // Conversion finished: hardware clears the start bit
    if (thermalConvDone) begin
      modeNxt[MODE_TEMP_BIT] = 1'b0; // RQ12
    end
    if (!active) begin
      // Deselect aborts any partial transfer; next byte is a command again
      stNxt = ST_CMD;
      bitsLeftNxt = CMD_BITS;
      doutOeNxt = 1'b0;
    end else begin
      case (stR)
        ST_CMD: begin
          doutOeNxt = 1'b0;
          if (sclkFall) begin
            shiftNxt = wrData;
            bitsLeftNxt = bitsLeftR - 5'h01;
            if (bitsLeftR == 5'h01) begin
              addrNxt = cmdByte[CMD_ADDR_MSB:0]; // RQ3 RQ2
              bitsLeftNxt = {regBytes(cmdByte[CMD_ADDR_MSB:0]), 3'b000}; // RQ17
              if (cmdByte[CMD_DIR_BIT]) begin
                stNxt = ST_WDATA; // RQ5
              end else begin
                stNxt = ST_RDATA; // RQ5
                shiftNxt = readAligned(cmdByte[CMD_ADDR_MSB:0], modeR, lineCycR);
              end
            end
          end
        end
        ST_WDATA: begin
          if (sclkFall) begin
            shiftNxt = wrData;
            bitsLeftNxt = bitsLeftR - 5'h01;
            if (bitsLeftR == 5'h01) begin
              stNxt = ST_CMD;
              bitsLeftNxt = CMD_BITS;
              if (addrR == MODE_ADDR) begin
                if (wrData[MODE_SOFTRST_BIT]) begin
                  // Software reset restores defaults and opens the quiet time
                  softRstNxt = 1'b1; // RQ13
                  modeNxt = MODE_RESET;
                  lineCycNxt = HALFCYC_RESET;
                  holdCntNxt = SOFTRST_QUIET_CNT; // RQ14
                end else begin
                  // A start written with a done pulse wins over the clear
                  modeNxt = wrData; // RQ6
                end
              end else if (addrR == HALFCYC_ADDR) begin
                lineCycNxt = wrData; // RQ16
              end
            end
          end
        end
        ST_RDATA: begin
          doutOeNxt = 1'b1;
          // Shift out on the rising edge, host samples on the falling edge
          if (sclkRise) begin
            doutNxt = shiftR[15]; // RQ17
            shiftNxt = {shiftR[14:0], 1'b0};
          end
          if (sclkFall) begin
            bitsLeftNxt = bitsLeftR - 5'h01;
            if (bitsLeftR == 5'h01) begin
              stNxt = ST_CMD;
              bitsLeftNxt = CMD_BITS;
            end
          end
        end
        default: begin
          stNxt = ST_CMD;
          bitsLeftNxt = CMD_BITS;
        end
      endcase
    end
  end

  // Register stage; reset dominates, clock enable freezes everything else
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stR <= ST_CMD;
      bitsLeftR <= CMD_BITS;
      shiftR <= 16'h0000;
      addrR <= 6'h00;
      modeR <= MODE_RESET; // RQ9 RQ10
      lineCycR <= HALFCYC_RESET; // RQ16
      holdCntR <= 8'h00;
      sclkD_r <= 1'b0;
      softRstR <= 1'b0;
      doutR <= 1'b0;
      doutOeR <= 1'b0;
    end else if (ce) begin
      stR <= stNxt;
      bitsLeftR <= bitsLeftNxt;
      shiftR <= shiftNxt;
      addrR <= addrNxt;
      modeR <= modeNxt;
      lineCycR <= lineCycNxt;
      holdCntR <= holdCntNxt;
      sclkD_r <= sclkD_nxt;
      softRstR <= softRstNxt;
      doutR <= doutNxt;
      doutOeR <= doutOeNxt;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flop
  assign dout = doutR;
  assign doutOe = doutOeR;
  assign ch1HighpassBypass = modeR[MODE_HPF_BIT]; // RQ7
  assign powerLowpassBypass = modeR[MODE_LOWPASS_BIT]; // RQ8
  assign pulseOutDisable = modeR[MODE_PULSE_BIT]; // RQ9
  assign dipDetectDisable = modeR[MODE_DIP_BIT]; // RQ10
  assign converterPowerdown = modeR[MODE_PWRDN_BIT]; // RQ11
  assign thermalConvStart = modeR[MODE_TEMP_BIT]; // RQ12
  assign halfcycleAccumMode = modeR[MODE_CYC_BIT]; // RQ15
  assign softChipReset = softRstR; // RQ13
  assign halfcycleCount = lineCycR; // RQ16
  assign modeUpper = modeR[15:8];

  // ==========================================================
  // Assertions
  a_mode_reset_val: assert property (@(posedge ref_clk) $fell(rst) |-> modeR == 16'h000C) // RQ9
    else $error("operating config reset value wrong");
  a_cyc_reset_val: assert property (@(posedge ref_clk) $fell(rst) |-> lineCycR == 16'hFFFF) // RQ16
    else $error("half-cycle count reset value wrong");
  a_addr_from_cmd: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
    cmdDone |=> addrR == $past(cmdByte[5:0]))
    else $error("target index not taken from command bits 0 to 5");
  a_dir_write: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
    cmdDone && cmdByte[7] |=> stR == ST_WDATA)
    else $error("command bit 7 high did not start a write");
  a_dir_read: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
    cmdDone && !cmdByte[7] |=> stR == ST_RDATA)
    else $error("command bit 7 low did not start a read");
  a_byte_count: assert property (@(posedge ref_clk) disable iff (rst) // RQ17
    cmdDone && (cmdByte[5:0] == 6'h09) |=> bitsLeftR == 5'h10)
    else $error("operating config transfer is not two bytes");
  a_softrst_reads0: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
    !modeR[6])
    else $error("software reset bit reads one");
  a_softrst_effect: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
    wrCommit && addrR == 6'h09 && wrData[6] |=> softRstR && modeR == 16'h000C
      && lineCycR == 16'hFFFF ##1 !softRstR || !ce)
    else $error("software reset did not restore defaults");
  a_mode_write: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
    wrCommit && addrR == 6'h09 && !wrData[6] |=> modeR == $past(wrData))
    else $error("operating config write not stored");
  a_temp_clear: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
    ce && thermalConvDone && !wrCommit |=> !modeR[5])
    else $error("thermal start bit not cleared on completion");
  a_quiet_deaf: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
    softRstR && ce |-> (stR == ST_CMD) [*8])
    else $error("serial port active in reset quiet time");

  c_read_xfer: cover property (@(posedge ref_clk) disable iff (rst) cmdDone && !cmdByte[7]);
  c_mode_write: cover property (@(posedge ref_clk) disable iff (rst) wrCommit && addrR == 6'h09);
  c_soft_reset: cover property (@(posedge ref_clk) disable iff (rst) softRstR);
  c_temp_done: cover property (@(posedge ref_clk) disable iff (rst) modeR[5] ##1 !modeR[5]);
endmodule

// [bench/mcr_host_model.sv]
`timescale 1ns/10ps
module mcr_host_model (
  input wire logic ref_clk,
  input wire logic dout,
  input wire logic doutOe,
  output logic sclk,
  output logic din,
  output logic csN
);
  logic lastBit = 1'b0;
  logic sdo;

  // ==========================================================
  // Data line seen by the host
  // A released line shows the inverse of its last bit, so stale data never matches
  assign sdo = doutOe ? dout : ~lastBit;
  always @(posedge ref_clk) begin
    if (doutOe) begin
      lastBit <= dout;
    end
  end

  // Idle: deselected, clock parked low
  initial begin
    sclk = 1'b0;
    din = 1'b0;
    csN = 1'b1;
  end

  // ==========================================================
  // One frame: command byte, then nb data bytes MSB first
  // Clock halves of six cycles keep well above the sampling limit of the synchronisers
  task automatic xfer(input logic [7:0] cmd, input int nb, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, (nb == 2) ? wd : {wd[7:0], 8'h00}};
    rd = '0;
    @(negedge ref_clk);
    csN = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      sclk = 1'b1;
      din = sh[23 - i];
      repeat (6) @(negedge ref_clk);
      if (i >= 8) begin
        rd = {rd[14:0], sdo};
      end
      sclk = 1'b0;
      repeat (6) @(negedge ref_clk);
    end
    // Give the device time to commit before deselecting
    repeat (8) @(negedge ref_clk);
    csN = 1'b1;
    din = ~din;
    repeat (4) @(negedge ref_clk);
  endtask

  // Cut frame: only the first nbits clocks, then deselect; the device must drop it
  task automatic cut(input logic [23:0] sh, input int nbits);
    @(negedge ref_clk);
    csN = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      din = sh[23 - i];
      repeat (6) @(negedge ref_clk);
      sclk = 1'b0;
      repeat (6) @(negedge ref_clk);
    end
    csN = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
  import mcr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic thermalConvDone = 1'b0;
  logic sclk, din, csN, dout, doutOe;
  logic ch1HighpassBypass, powerLowpassBypass, pulseOutDisable, dipDetectDisable;
  logic converterPowerdown, thermalConvStart, halfcycleAccumMode, softChipReset;
  logic [15:0] halfcycleCount;
  logic [7:0] modeUpper;
  logic [15:0] pins;
  logic [31:0] seed = 32'hB9A5E5BE;
  int failCount = 0;
  int checks = 0;
  int softRstSeen = 0;

  // ==========================================================
  // Clock and devices
  always #50 ref_clk = ~ref_clk;

  mcr_cmd_mode_regs mcr_cmd_mode_regs_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .sclk(sclk), .din(din), .csN(csN), .thermalConvDone(thermalConvDone), .dout(dout),
    .doutOe(doutOe), .ch1HighpassBypass(ch1HighpassBypass),
    .powerLowpassBypass(powerLowpassBypass), .pulseOutDisable(pulseOutDisable),
    .dipDetectDisable(dipDetectDisable), .converterPowerdown(converterPowerdown),
    .thermalConvStart(thermalConvStart), .halfcycleAccumMode(halfcycleAccumMode),
    .softChipReset(softChipReset), .halfcycleCount(halfcycleCount), .modeUpper(modeUpper));

  mcr_host_model mcr_host_model_inst (.ref_clk(ref_clk), .dout(dout), .doutOe(doutOe),
    .sclk(sclk), .din(din), .csN(csN));

  // Mode pins packed in register order; the reset bit is never a level
  assign pins = {modeUpper, halfcycleAccumMode, 1'b0, thermalConvStart, converterPowerdown,
                 dipDetectDisable, pulseOutDisable, powerLowpassBypass, ch1HighpassBypass};

  // Count software reset pulses
  always @(posedge ref_clk) begin
    if (softChipReset === 1'b1) begin
      softRstSeen <= softRstSeen + 1;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int nbOf(input logic [5:0] a);
    return (a == MODE_ADDR || a == HALFCYC_ADDR) ? 2 : 1;
  endfunction

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Command bit 6 is always sent as zero
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    logic [15:0] d;
    mcr_host_model_inst.xfer({2'b10, a}, nbOf(a), v, d);
  endtask

  task automatic rdChk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    mcr_host_model_inst.xfer({2'b00, a}, nbOf(a), 16'h0000, d);
    cmp(d, exp);
  endtask

  // ==========================================================
  // Watchdog sized well past the expected run of about 14k cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    failCount++;
    testDone();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] m;
    logic [15:0] c;
    logic [5:0] a;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    cmp(pins, MODE_RESET);
    cmp(halfcycleCount, HALFCYC_RESET);
    rdChk(MODE_ADDR, MODE_RESET);
    rdChk(HALFCYC_ADDR, HALFCYC_RESET);
    for (int k = 0; k < 6; k++) begin
      // First pass sets every low bit except the reset bit
      m = (k == 0) ? 16'h00BF : 16'(rnd()) & 16'hFFBF;
      wr(MODE_ADDR, m);
      cmp(pins, m);
      rdChk(MODE_ADDR, m);
      thermalConvDone = 1'b1;
      @(negedge ref_clk);
      thermalConvDone = 1'b0;
      @(negedge ref_clk);
      m[MODE_TEMP_BIT] = 1'b0;
      cmp(pins, m);
      c = 16'(rnd());
      wr(HALFCYC_ADDR, c);
      cmp(halfcycleCount, c);
      a = 6'(rnd());
      if (a == MODE_ADDR || a == HALFCYC_ADDR) begin
        a = 6'h3F;
      end
      wr(a, 16'(rnd()));
      rdChk(a, 16'h0000);
      rdChk(MODE_ADDR, m);
      rdChk(HALFCYC_ADDR, c);
    end
    // Write frame cut four bits early: the stored value must survive
    mcr_host_model_inst.cut({2'b10, MODE_ADDR, 16'h1234}, 20);
    rdChk(MODE_ADDR, m);
    // Clock enable low freezes the start bit against a done pulse
    wr(MODE_ADDR, 16'h0020);
    ce = 1'b0;
    thermalConvDone = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp(pins, 16'h0020);
    ce = 1'b1;
    @(negedge ref_clk);
    thermalConvDone = 1'b0;
    @(negedge ref_clk);
    cmp(pins, 16'h0000);
    // Software reset, then stay quiet for the whole guard time
    wr(MODE_ADDR, 16'h00C0);
    repeat (SOFTRST_QUIET_CYC + 20) @(negedge ref_clk);
    cmp(16'(softRstSeen), 16'h0001);
    cmp(pins, MODE_RESET);
    rdChk(MODE_ADDR, MODE_RESET);
    rdChk(HALFCYC_ADDR, HALFCYC_RESET);
    testDone();
  end
endmodule
